// ---- core/apd_unit.sv ----
`timescale 1ns/1ps
`include "apd_defs.svh"
module apd_unit
  import apd_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic por_i,
  input wire logic strobe_pin_i,
  input wire logic clock_pin_i,
  input wire logic select_pin_n_i,
  input wire logic device_reset_i,
  input wire logic cntl0_i,
  input wire logic cntl1_i,
  input wire logic cntl2_i,
  input wire logic dbe_i,
  input wire logic reg_we_first_i,
  input wire logic reg_we_block_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] power_ctrl_reg_first_o,
  output logic [7:0] power_ctrl_block_o,
  output logic power_down_flag_o,
  output apd_gate_s gate_o,
  output apd_power_s power_o
);
  // State layout, all held in one registered struct:
  // - two-stage synchronisers for the strobe, logic clock, select and reset pins
  // - one stage for the MCU control lines, which only feed the array gates
  // - previous synchronised levels for the strobe and logic clock edge detectors
  // - the first control register and the blocking register
  // - the power-down mode and the registered gate and power outputs
  // The control registers share the struct but have their own reset policy,
  // so the register process below clears them on power-up only.
  // Limitation: the logic clock pin must run much slower than clk_i,
  // otherwise its rising edges are lost in the synchroniser.
  // Limitation: a strobe faster than half the clk_i rate aliases and may
  // look idle; the host bus strobe is far slower in practice.
  typedef struct packed {
    logic [1:0] strobe_sync;
    logic [1:0] clock_sync;
    logic [1:0] select_sync;
    logic [1:0] reset_sync;
    logic [3:0] ctl_sync;
    logic strobe_prev;
    logic clock_prev;
    logic [7:0] reg_first;
    logic [7:0] reg_block;
    apd_mode_e mode;
    apd_gate_s gate;
    apd_power_s power;
  } apd_state_s;

  apd_state_s st_r;
  apd_state_s st_nxt;
  logic strobe_act;
  logic clock_tick;
  logic idle_expired;
  logic unit_on;

  // Either edge of the strobe counts as activity, so a strobe parked
  // high or low after the host stops both read as idle.
  // The detector starts from the reset level of its synchroniser,
  // so no false edge follows reset.
  // Edge of a synchronised level, read only after the second stage
  function automatic logic apd_edge(input logic now_v, input logic prev_v);
    apd_edge = now_v ^ prev_v;
  endfunction : apd_edge

  assign strobe_act = apd_edge(st_r.strobe_sync[1], st_r.strobe_prev);
  // Rising edges of the logic clock pin mark one period
  assign clock_tick = st_r.clock_sync[1] && !st_r.clock_prev;
  assign unit_on = st_r.reg_first[`APD_BIT_ENABLE];

  // The counter is a separate module so its saturation and expiry rules
  // can be read on their own.
  // It is cleared whenever the unit is disabled, so re-enabling always
  // starts a fresh idle count of fifteen periods.
  // Counter sees the raw clock tick, independent of the array clock blocking bits
  apd_idle_counter u_idle (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .run_i(unit_on),
    .activity_i(strobe_act),
    .tick_i(clock_tick),
    .expired_o(idle_expired)
  );

  always_comb begin
    st_nxt = st_r;
    // Two-flop synchronisers for every pin except the control lines, which get one flop
    st_nxt.strobe_sync = {st_r.strobe_sync[0], strobe_pin_i};
    st_nxt.clock_sync = {st_r.clock_sync[0], clock_pin_i};
    st_nxt.select_sync = {st_r.select_sync[0], select_pin_n_i};
    st_nxt.reset_sync = {st_r.reset_sync[0], device_reset_i};
    st_nxt.ctl_sync = {cntl0_i, cntl1_i, cntl2_i, dbe_i};
    st_nxt.strobe_prev = st_r.strobe_sync[1];
    st_nxt.clock_prev = st_r.clock_sync[1];
    // Writes accepted at any time except during power-up clear
    if (reg_we_first_i) begin
      st_nxt.reg_first = reg_wdata_i;
    end
    if (reg_we_block_i) begin
      st_nxt.reg_block = reg_wdata_i;
    end
    // Mode control; select and reset wakes win over expiry, a strobe edge in the same cycle does not
    // The counter holds its terminal count while the strobe stays quiet.
    // Without the extra terms below, a wake by select or reset would be
    // followed by re-entry on the next cycle and the flag would toggle.
    // Entry therefore also needs the same wake causes to be absent,
    // so the device stays awake for as long as select is low or reset high.
    unique case (st_r.mode)
      APD_ST_NORMAL: begin
        if (unit_on && idle_expired && st_r.select_sync[1] &&
            !st_r.reset_sync[1]) begin
          st_nxt.mode = APD_ST_DOWN;
        end
      end
      APD_ST_DOWN: begin
        if (strobe_act) begin
          st_nxt.mode = APD_ST_NORMAL;
        end else if (!st_r.select_sync[1] || st_r.reset_sync[1] || !unit_on) begin
          st_nxt.mode = APD_ST_NORMAL;
        end
      end
    endcase
    // The arrays stay active in power-down so their outputs can change
    // without a wake-up delay; only the strobe is cut, since it belongs
    // to the blocked MCU bus.
    // Blocking bits can be set before power-down to save array power.
    // Array inputs gated by blocking bits, clocks by first register bits; only the strobe also by power-down
    st_nxt.gate.cntl0 = st_r.ctl_sync[3] && !st_r.reg_block[`APD_BIT_BLK_CNTL0];
    st_nxt.gate.cntl1 = st_r.ctl_sync[2] && !st_r.reg_block[`APD_BIT_BLK_CNTL1];
    st_nxt.gate.cntl2 = st_r.ctl_sync[1] && !st_r.reg_block[`APD_BIT_BLK_CNTL2];
    st_nxt.gate.dbe = st_r.ctl_sync[0] && !st_r.reg_block[`APD_BIT_BLK_DBE];
    st_nxt.gate.strobe = st_r.strobe_sync[1] &&
                         !st_r.reg_block[`APD_BIT_BLK_STROBE] &&
                         (st_r.mode == APD_ST_NORMAL);
    st_nxt.gate.array_clk = st_r.clock_sync[1] &&
                            !st_r.reg_first[`APD_BIT_ARRAY_CLK_OFF];
    st_nxt.gate.mcell_clk = st_r.clock_sync[1] &&
                            !st_r.reg_first[`APD_BIT_MCELL_CLK_OFF];
    // Select high turns memories and I/O ports off but keeps the arrays up.
    // Power-down deselects the memories internally even while select is low
    // for the one cycle before the wake takes effect.
    // Only the data port floats in power-down; io_select follows select alone.
    // Memory, register block and port controls
    st_nxt.power.bus_block = (st_r.mode == APD_ST_DOWN);
    st_nxt.power.mem_select = (st_r.mode == APD_ST_NORMAL) &&
                              !st_r.select_sync[1];
    st_nxt.power.io_select = !st_r.select_sync[1];
    // Standby in power-down and whenever deselected
    st_nxt.power.mem_standby = (st_r.mode == APD_ST_DOWN) ||
                               st_r.select_sync[1];
    st_nxt.power.data_port_tristate = (st_r.mode == APD_ST_DOWN);
    // Turbo follows its bit alone, so power-down leaves logic timing untouched
    st_nxt.power.turbo_off = st_r.reg_first[`APD_BIT_TURBO_OFF];
  end

  // Power-up clear presets the select synchroniser to the deselected level,
  // so memories do not see a false select in the first cycles.
  // The system reset keeps the synchronisers and registers running, which
  // lets writes made during reset land and avoids a false edge on release.
  // Mode, gates and power outputs return to their idle values.
  // Control registers clear on power-up only; device reset does not touch them
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      st_r <= '0;
      st_r.reg_first <= `APD_REG_RESET;
      st_r.reg_block <= `APD_REG_RESET;
      st_r.select_sync <= 2'h3;
      st_r.power.io_select <= 1'b0;
    end else if (srst_i) begin
      st_r.mode <= APD_ST_NORMAL;
      st_r.reg_first <= st_nxt.reg_first;
      st_r.reg_block <= st_nxt.reg_block;
      st_r.strobe_sync <= st_nxt.strobe_sync;
      st_r.clock_sync <= st_nxt.clock_sync;
      st_r.select_sync <= st_nxt.select_sync;
      st_r.reset_sync <= st_nxt.reset_sync;
      st_r.ctl_sync <= st_nxt.ctl_sync;
      st_r.strobe_prev <= st_nxt.strobe_prev;
      st_r.clock_prev <= st_nxt.clock_prev;
      st_r.gate <= '0;
      st_r.power <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Every output is a register field; no logic sits between flop and port.
  // Latched address outputs are not produced here; their level in
  // power-down is left undefined by the port logic.
  // Pins in I/O or logic-output function are not driven here and keep their level
  assign power_ctrl_reg_first_o = st_r.reg_first;
  assign power_ctrl_block_o = st_r.reg_block;
  assign power_down_flag_o = (st_r.mode == APD_ST_DOWN);
  assign gate_o = st_r.gate;
  assign power_o = st_r.power;
endmodule : apd_unit

// ---- core/apd_defs.svh ----
`ifndef APD_DEFS_SVH
`define APD_DEFS_SVH
// Field positions in the first power control register
`define APD_BIT_ENABLE 1
`define APD_BIT_TURBO_OFF 3
`define APD_BIT_ARRAY_CLK_OFF 4
`define APD_BIT_MCELL_CLK_OFF 5
// Field positions in the blocking register
`define APD_BIT_BLK_CNTL0 2
`define APD_BIT_BLK_CNTL1 3
`define APD_BIT_BLK_CNTL2 4
`define APD_BIT_BLK_STROBE 5
`define APD_BIT_BLK_DBE 6
// Power-up value of both control registers
`define APD_REG_RESET 8'h00
// Idle periods before power-down
`define APD_IDLE_LIMIT 4'hF
`define APD_CNT_ZERO 4'h0
`define APD_CNT_ONE 4'h1
`endif

// ---- core/apd_pkg.sv ----
package apd_pkg;
  typedef enum logic [0:0] {
    APD_ST_NORMAL = 1'b0,
    APD_ST_DOWN = 1'b1
  } apd_mode_e;

  // Gated MCU signals toward the logic arrays
  typedef struct packed {
    logic cntl0;
    logic cntl1;
    logic cntl2;
    logic strobe;
    logic dbe;
    logic array_clk;
    logic mcell_clk;
  } apd_gate_s;

  // Memory and port power controls
  typedef struct packed {
    logic bus_block;
    logic mem_select;
    logic io_select;
    logic mem_standby;
    logic data_port_tristate;
    logic turbo_off;
  } apd_power_s;
endpackage : apd_pkg

// ---- core/apd_idle_counter.sv ----
`timescale 1ns/1ps
`include "apd_defs.svh"
// Four-bit idle counter advanced by logic clock periods
module apd_idle_counter
  import apd_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic run_i,
  input wire logic activity_i,
  input wire logic tick_i,
  output logic expired_o
);
  typedef struct packed {
    logic [3:0] cnt;
    logic expired;
  } apd_cnt_s;

  apd_cnt_s st_r;
  apd_cnt_s st_nxt;

  // Clear on activity, count ticks, saturate at the limit
  always_comb begin
    st_nxt = st_r;
    if (!run_i || activity_i) begin
      st_nxt.cnt = `APD_CNT_ZERO;
    end else if (tick_i && st_r.cnt != `APD_IDLE_LIMIT) begin
      st_nxt.cnt = st_r.cnt + `APD_CNT_ONE;
    end
    st_nxt.expired = run_i && !activity_i &&
                     (st_nxt.cnt == `APD_IDLE_LIMIT);
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign expired_o = st_r.expired;
endmodule : apd_idle_counter

// ---- verif/apd_props.sv ----
`timescale 1ns/1ps
// Port-level checks of the power-down unit
module apd_props
  import apd_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic por_i,
  input wire logic strobe_pin_i,
  input wire logic select_pin_n_i,
  input wire logic reg_we_first_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] power_ctrl_reg_first_o,
  input wire logic [7:0] power_ctrl_block_o,
  input wire logic power_down_flag_o,
  input wire apd_power_s power_o
);
  default clocking cb @(posedge clk_i); endclocking
  // Register checks only drop out on power-up clear, reset must not touch them
  a_reg_write_seen: assert property (disable iff (por_i) reg_we_first_i |=>
    power_ctrl_reg_first_o == $past(reg_wdata_i)) else $error("first reg write lost");
  a_regs_keep_rst: assert property (disable iff (por_i) srst_i && !reg_we_first_i |=>
    $stable(power_ctrl_reg_first_o)) else $error("reset changed first reg");
  a_por_clears: assert property (por_i |=> power_ctrl_reg_first_o == 8'h00 &&
    power_ctrl_block_o == 8'h00 && !power_down_flag_o) else $error("power-up clear");
  a_down_blocks: assert property (disable iff (srst_i || por_i) $rose(power_down_flag_o)
    |-> ##[0:2] power_o.bus_block && power_o.mem_standby) else $error("bus not blocked");
  a_down_needs_en: assert property (disable iff (srst_i || por_i)
    $rose(power_down_flag_o) |-> power_ctrl_reg_first_o[1]) else $error("down while off");
  a_select_wakes: assert property (disable iff (srst_i || por_i)
    $fell(select_pin_n_i) |-> ##[1:5] !power_down_flag_o) else $error("select no wake");
  a_strobe_wakes: assert property (disable iff (srst_i || por_i)
    $changed(strobe_pin_i) && power_down_flag_o |-> ##[1:6] !power_down_flag_o)
    else $error("strobe no wake");
  a_turbo_follows: assert property (disable iff (srst_i || por_i)
    !$past(srst_i) && !$past(por_i) |-> power_o.turbo_off == $past(power_ctrl_reg_first_o[3]))
    else $error("turbo mismatch");
endmodule : apd_props

// ---- verif/apd_mcu_model.sv ----
`timescale 1ns/1ps
// MCU side: address strobe and a free-running oscillator on the clock pin
module apd_mcu_model (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic run_i,
  output logic strobe_o,
  output logic clock_pin_o
);
  logic [3:0] div_r;
  // Oscillator period is 16 clocks, slow enough for the pin synchroniser
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      div_r <= 4'h0;
      strobe_o <= 1'b0;
    end else begin
      div_r <= div_r + 4'h1;
      if (run_i) begin
        strobe_o <= div_r[1]; // Strobe holds its level once the bus sleeps
      end
    end
  end
  assign clock_pin_o = div_r[3]; // Free-running logic clock
endmodule : apd_mcu_model

// ---- verif/tb_apd_unit.sv ----
`timescale 1ns/1ps
module tb_apd_unit;
  import apd_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic por_i = 1'b1;
  logic run = 1'b1;
  logic sel_n = 1'b0;
  logic dev_rst = 1'b0;
  logic [3:0] cntl = 4'h0;
  logic we_f = 1'b0;
  logic we_b = 1'b0;
  logic [7:0] wd = 8'h00;
  logic [7:0] rd;
  logic stb, cpin, flag;
  logic [7:0] rf, rb;
  apd_gate_s gate;
  apd_power_s pwr;
  int err_total = 0;
  int checked = 0;
  typedef struct {int sel; logic [7:0] exp;} apd_note_s;
  apd_note_s notes[$];
  apd_note_s cur;
  event go;
  apd_mcu_model apd_mcu_model_i (.clk_i(clk_i), .srst_i(srst_i), .run_i(run),
    .strobe_o(stb), .clock_pin_o(cpin));
  apd_unit apd_unit_i (.clk_i(clk_i), .srst_i(srst_i), .por_i(por_i), .strobe_pin_i(stb),
    .clock_pin_i(cpin), .select_pin_n_i(sel_n), .device_reset_i(dev_rst),
    .cntl0_i(cntl[0]), .cntl1_i(cntl[1]), .cntl2_i(cntl[2]), .dbe_i(cntl[3]),
    .reg_we_first_i(we_f), .reg_we_block_i(we_b), .reg_wdata_i(wd),
    .power_ctrl_reg_first_o(rf), .power_ctrl_block_o(rb), .power_down_flag_o(flag),
    .gate_o(gate), .power_o(pwr));
  initial forever #5 clk_i = ~clk_i;
  task automatic print_verdict();
    if (err_total == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  task automatic cyc(int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  // Write pulse with fresh random control inputs; 3 cycles let gates settle
  task automatic wr(logic blk, logic [7:0] d);
    @(posedge clk_i);
    {we_f, we_b, wd} <= {!blk, blk, d};
    cntl <= $urandom;
    @(posedge clk_i);
    {we_f, we_b} <= 2'b00;
    cyc(3);
  endtask : wr
  // Expectation goes in the queue mid-cycle, when outputs are settled
  task automatic note(int sel, logic [7:0] exp);
    @(negedge clk_i);
    notes.push_back('{sel, exp});
    ->go;
    @(posedge clk_i);
  endtask : note
  task automatic rises(int n);
    repeat (n) @(posedge cpin);
    cyc(9);
  endtask : rises
  task automatic wait_flag();
    for (int i = 0; i < 400 && flag !== 1'b1; i++) @(posedge clk_i);
    if (flag !== 1'b1) begin
      err_total++;
      print_verdict();
    end
  endtask : wait_flag
  // Monitor: oldest note against the output it names
  always @(go) begin
    cur = notes.pop_front();
    case (cur.sel)
      0: rd = rf;
      1: rd = rb;
      2: rd = {7'h00, flag};
      3: rd = {7'h00, pwr.turbo_off};
      4: rd = {1'b0, gate};
      default: rd = {3'h0, pwr.io_select, pwr.data_port_tristate, pwr.bus_block,
        pwr.mem_select, pwr.mem_standby};
    endcase
    checked++;
    if (rd !== cur.exp) begin
      err_total++;
      $display("[FAIL] %0t sel %0d seen %h exp %h", $time, cur.sel, rd, cur.exp);
    end
  end
  initial begin
    void'($urandom(32'h8172));
    cyc(8);
    {srst_i, por_i, sel_n} <= 3'b001;
    note(0, 8'h00);
    note(1, 8'h00);
    for (int k = 0; k < 6; k++) begin
      wr(k[0], 8'($urandom));
      note(k[0], wd);
    end
    wr(1'b1, 8'h00);
    wr(1'b0, 8'h02);
    // Stop the strobe just after a clock pin rise so the count starts clean
    @(posedge cpin);
    @(posedge clk_i);
    run <= 1'b0;
    rises(14);
    note(2, 8'h00);
    rises(1);
    note(2, 8'h01);
    note(5, 8'h0D);
    run <= 1'b1;
    cyc(8);
    note(2, 8'h00);
    run <= 1'b0;
    wait_flag();
    sel_n <= 1'b0;
    cyc(6);
    note(2, 8'h00);
    sel_n <= 1'b1;
    wait_flag();
    dev_rst <= 1'b1;
    cyc(6);
    note(2, 8'h00);
    dev_rst <= 1'b0;
    wr(1'b0, 8'h00);
    rises(20);
    note(2, 8'h00);
    wr(1'b0, 8'h38);
    wr(1'b1, 8'h7C);
    note(3, 8'h01);
    note(4, 8'h00);
    srst_i <= 1'b1;
    cyc(2);
    srst_i <= 1'b0;
    note(0, 8'h38);
    por_i <= 1'b1;
    cyc(2);
    por_i <= 1'b0;
    cyc(3);
    note(0, 8'h00);
    note(3, 8'h00);
    cyc(2);
    print_verdict();
  end
endmodule : tb_apd_unit
bind apd_unit apd_props apd_props_i (.*);
